// [hmi_char_tx.sv]
// character transmitter: start, data, even parity, one stop bit
`include "hmi_link_consts.svh"
module hmi_char_tx #(
  parameter int BIT_CYCLES = `BIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // request side
  tx_link_if.engine lnk,
  // line
  output logic txd
);
  import hmi_link_pkg::*;

  localparam logic [`CNT_W-1:0] LAST_CNT = `CNT_W'(BIT_CYCLES - 1);

  tx_state_t state;
  logic [`CNT_W-1:0] cnt;
  logic [7:0] shreg;
  logic [2:0] bitn;
  logic par;
  logic seven;

  ////////////////////////////////////////////////////////////////////////////
  // a started character always runs to its stop bit; pausing is decided
  // only between characters by the controller
  assign lnk.busy = (state != TX_IDLE);

  // bit timing and framing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= TX_IDLE;
      cnt <= '0;
      shreg <= 8'h00;
      bitn <= 3'h0;
      par <= 1'b0;
      seven <= 1'b0;
      txd <= `LINE_IDLE;
    end else if (ce) begin
      case (state)
        TX_IDLE: begin
          txd <= `LINE_IDLE;
          cnt <= '0;
          if (lnk.start) begin
            shreg <= lnk.data;
            seven <= lnk.seven_bits;
            // even parity over the bits actually sent
            par <= lnk.seven_bits ? ^lnk.data[6:0] : ^lnk.data;
            txd <= `LINE_START;
            state <= TX_START;
          end
        end
        TX_START: begin
          if (cnt == LAST_CNT) begin
            cnt <= '0;
            txd <= shreg[0];
            bitn <= 3'h0;
            state <= TX_DATA;
          end else begin
            cnt <= cnt + `CNT_W'(1);
          end
        end
        TX_DATA: begin
          if (cnt == LAST_CNT) begin
            cnt <= '0;
            if (bitn == (seven ? `LAST_BIT_7 : `LAST_BIT_8)) begin
              txd <= par;
              state <= TX_PAR;
            end else begin
              txd <= shreg[1];
              shreg <= {1'b0, shreg[7:1]};
              bitn <= bitn + 3'h1;
            end
          end else begin
            cnt <= cnt + `CNT_W'(1);
          end
        end
        TX_PAR: begin
          if (cnt == LAST_CNT) begin
            cnt <= '0;
            txd <= `LINE_IDLE;
            state <= TX_STOP;
          end else begin
            cnt <= cnt + `CNT_W'(1);
          end
        end
        TX_STOP: begin
          if (cnt == LAST_CNT) begin
            cnt <= '0;
            state <= TX_IDLE;
          end else begin
            cnt <= cnt + `CNT_W'(1);
          end
        end
        default: begin
          state <= TX_IDLE;
          txd <= `LINE_IDLE;
        end
      endcase
    end
  end
endmodule // hmi_char_tx

// [hmi_link_consts.svh]
// named constants of the serial link controller
`ifndef HMI_LINK_CONSTS_SVH
`define HMI_LINK_CONSTS_SVH
// timing
`define CLK_HZ 100000000
`define LINE_BPS 19200
`define BIT_CYCLES (`CLK_HZ / `LINE_BPS)
`define CNT_W 13
// character format
`define LAST_BIT_8 3'h7
`define LAST_BIT_7 3'h6
`define LINE_IDLE 1'b1
`define LINE_START 1'b0
// register byte offsets
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_TXDATA 5'h08
`define REG_RXDATA 5'h0C
`define REG_CHECK 5'h10
`define REG_STATION 5'h14
// control fields
`define CTRL_HOST 0
`define CTRL_SUMCLR 1
// status fields
`define ST_TXBUSY 0
`define ST_RXVALID 1
`define ST_PARERR 2
`define ST_FRMERR 3
`define ST_OVERRUN 4
`define ST_SUMZERO 5
`define ST_DSR 6
`define ST_DTR 7
`define ST_TXFULL 8
// reset values
`define STATION_RST 8'h00
`endif

// [hmi_link_pkg.sv]
// types shared by the serial link controller files
package hmi_link_pkg;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;
endpackage

// [hmi_peer_model.sv]
// far-side serial peer: sends on request and decodes the terminal's output
module hmi_peer_model #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input wire logic mclk,
  // line
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STATION = 0;
  logic [7:0] rx_q [$];
  int err_cnt = 0;
  initial rxd = 1'b1;
  // only speaks when the bench asks, never on its own
  task automatic send_char(input logic [7:0] b, input logic bad_par);
    logic [10:0] frame;
    frame = {1'b1, ^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk);
      rxd <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge mclk);
    end
  endtask
  // every character is kept, repeats included
  always begin
    logic [9:0] bits;
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYCLES) @(posedge mclk);
      bits[i] = txd;
    end
    rx_q.push_back(bits[7:0]);
    if ((^bits[8:0]) !== 1'b0 || bits[9] !== 1'b1) err_cnt++;
  end
endmodule // hmi_peer_model

// [hmi_serial_link_ctrl.sv]
// serial link controller of an operator terminal port with avalon slave
//
// Behaviour
// - line runs at 19200 bits per second
// - eight data bits, even parity, one stop
// - block check sum protects and checks messages
// - host link starts no character while ready-in low
// - ready-out high only while receiver can accept
`include "hmi_link_consts.svh"
module hmi_serial_link_ctrl #(
  parameter int BIT_CYCLES = `BIT_CYCLES
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial line and modem control
  input wire logic rxd,
  output logic txd,
  input wire logic dsr,
  output logic dtr
);
  import hmi_link_pkg::*;

  localparam logic [`CNT_W-1:0] LAST_CNT = `CNT_W'(BIT_CYCLES - 1);
  localparam logic [`CNT_W-1:0] HALF_CNT = `CNT_W'(BIT_CYCLES / 2 - 1);

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  tx_link_if lnk ();

  logic rxd_meta, rxd_s, dsr_meta, dsr_s;
  logic ack, wr_en, rd_en;
  logic mode_host;
  logic [7:0] station;
  logic tx_pend;
  logic [7:0] tx_hold;
  logic [7:0] tx_sum, rx_sum;
  rx_state_t rx_state;
  logic [`CNT_W-1:0] rx_cnt;
  logic [7:0] rx_sh;
  logic [2:0] rx_bitn;
  logic rx_parbit;
  logic rx_fire;
  logic [7:0] rx_byte;
  logic rx_perr, rx_ferr;
  logic rx_valid, next_rx_valid;
  logic [7:0] rx_data;
  logic par_err, frm_err, overrun;
  logic rd_rx, accept, sum_clr, err_clr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage feeds only the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_meta <= `LINE_IDLE;
      rxd_s <= `LINE_IDLE;
      dsr_meta <= 1'b0;
      dsr_s <= 1'b0;
    end else if (ce) begin
      rxd_meta <= rxd;
      rxd_s <= rxd_meta;
      dsr_meta <= dsr;
      dsr_s <= dsr_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus: one wait cycle per access, the second edge completes it
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en = avs_write & ack;
  assign rd_en = avs_read & ack;
  assign rd_rx = rd_en & hit(avs_address, `REG_RXDATA);
  assign sum_clr = wr_en & hit(avs_address, `REG_CTRL) &
                   avs_writedata[`CTRL_SUMCLR];
  assign err_clr_hit = wr_en & hit(avs_address, `REG_STATUS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // read data is latched in the wait cycle and stands at the completing edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (ce && avs_read && !ack) begin
      avs_readdata <= 32'h00000000;
      if (hit(avs_address, `REG_CTRL)) begin
        avs_readdata[`CTRL_HOST] <= mode_host;
      end else if (hit(avs_address, `REG_STATUS)) begin
        avs_readdata[`ST_TXBUSY] <= lnk.busy;
        avs_readdata[`ST_RXVALID] <= rx_valid;
        avs_readdata[`ST_PARERR] <= par_err;
        avs_readdata[`ST_FRMERR] <= frm_err;
        avs_readdata[`ST_OVERRUN] <= overrun;
        avs_readdata[`ST_SUMZERO] <= (rx_sum == 8'h00);
        avs_readdata[`ST_DSR] <= dsr_s;
        avs_readdata[`ST_DTR] <= dtr;
        avs_readdata[`ST_TXFULL] <= tx_pend;
      end else if (hit(avs_address, `REG_RXDATA)) begin
        avs_readdata[7:0] <= rx_data;
      end else if (hit(avs_address, `REG_CHECK)) begin
        // two's complement of the sent sum closes a message to zero
        avs_readdata[7:0] <= 8'h00 - tx_sum;
        avs_readdata[15:8] <= rx_sum;
      end else if (hit(avs_address, `REG_STATION)) begin
        avs_readdata[7:0] <= station;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_host <= 1'b0;
      station <= `STATION_RST;
    end else if (ce && wr_en) begin
      if (hit(avs_address, `REG_CTRL)) begin
        mode_host <= avs_writedata[`CTRL_HOST];
      end
      if (hit(avs_address, `REG_STATION)) begin
        station <= avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit holding byte; a write while it is full replaces the held byte, except in the cycle that byte launches, when the write is lost
  // the controller link launches freely, the host link waits for ready-in
  assign lnk.seven_bits = 1'b0;
  assign lnk.data = tx_hold;
  assign lnk.start = tx_pend & ~lnk.busy &
                     (~mode_host | dsr_s);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_pend <= 1'b0;
      tx_hold <= 8'h00;
    end else if (ce) begin
      if (lnk.start) begin
        tx_pend <= 1'b0;
      end else if (wr_en && hit(avs_address, `REG_TXDATA)) begin
        tx_pend <= 1'b1;
        tx_hold <= avs_writedata[7:0];
      end
    end
  end

  // running block sums; an add in the clearing cycle survives
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sum <= 8'h00;
      rx_sum <= 8'h00;
    end else if (ce) begin
      tx_sum <= (sum_clr ? 8'h00 : tx_sum) +
                (lnk.start ? tx_hold : 8'h00);
      rx_sum <= (sum_clr ? 8'h00 : rx_sum) +
                (rx_fire ? rx_byte : 8'h00);
    end
  end

  hmi_char_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .lnk(lnk.engine),
    .txd(txd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receiver: samples mid-bit, start bit rechecked at half a bit
  assign rx_fire = (rx_state == RX_STOP) && (rx_cnt == LAST_CNT);
  assign rx_byte = rx_sh;
  assign rx_perr = rx_fire && ((^rx_sh) != rx_parbit);
  assign rx_ferr = rx_fire && (rxd_s != `LINE_IDLE);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_sh <= 8'h00;
      rx_bitn <= 3'h0;
      rx_parbit <= 1'b0;
    end else if (ce) begin
      case (rx_state)
        RX_IDLE: begin
          rx_cnt <= '0;
          if (rxd_s == `LINE_START) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt == HALF_CNT) begin
            rx_cnt <= '0;
            rx_bitn <= 3'h0;
            // a glitch shorter than half a bit is dropped
            rx_state <= (rxd_s == `LINE_START) ? RX_DATA : RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt + `CNT_W'(1);
          end
        end
        RX_DATA: begin
          if (rx_cnt == LAST_CNT) begin
            rx_cnt <= '0;
            rx_sh <= {rxd_s, rx_sh[7:1]};
            rx_bitn <= rx_bitn + 3'h1;
            if (rx_bitn == `LAST_BIT_8) begin
              rx_state <= RX_PAR;
            end
          end else begin
            rx_cnt <= rx_cnt + `CNT_W'(1);
          end
        end
        RX_PAR: begin
          if (rx_cnt == LAST_CNT) begin
            rx_cnt <= '0;
            rx_parbit <= rxd_s;
            rx_state <= RX_STOP;
          end else begin
            rx_cnt <= rx_cnt + `CNT_W'(1);
          end
        end
        RX_STOP: begin
          if (rx_cnt == LAST_CNT) begin
            rx_cnt <= '0;
            rx_state <= RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt + `CNT_W'(1);
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer and sticky errors; a new byte wins over a clear
  assign accept = ~rx_valid | rd_rx;
  assign next_rx_valid = (rx_fire & accept) | (rx_valid & ~rd_rx);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      dtr <= 1'b0;
    end else if (ce) begin
      rx_valid <= next_rx_valid;
      if (rx_fire && accept) begin
        rx_data <= rx_byte;
      end
      // ready-out follows the buffer so the host can pace itself
      dtr <= mode_host & ~next_rx_valid;
    end
  end

  // write one to clear; a fresh error in the same cycle stays set
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      par_err <= 1'b0;
      frm_err <= 1'b0;
      overrun <= 1'b0;
    end else if (ce) begin
      par_err <= rx_perr | (par_err &
                 ~(err_clr_hit & avs_writedata[`ST_PARERR]));
      frm_err <= rx_ferr | (frm_err &
                 ~(err_clr_hit & avs_writedata[`ST_FRMERR]));
      overrun <= (rx_fire & ~accept) | (overrun &
                 ~(err_clr_hit & avs_writedata[`ST_OVERRUN]));
    end
  end
endmodule // hmi_serial_link_ctrl

// [hmi_serial_link_ctrl_sva.sv]
// port checker for the serial link controller
module hmi_link_checker #(
  parameter int BIT_CYCLES = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // line
  input wire logic txd,
  input wire logic dtr
);
  timeunit 1ns;
  timeprecision 1ps;
  int fcnt;
  int lo_cnt;
  logic px;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // position within a transmitted frame; zero while the line idles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) fcnt <= 0;
    else if (fcnt == 0) fcnt <= txd ? 0 : 1;
    else fcnt <= (fcnt == 11 * BIT_CYCLES - 1) ? 0 : fcnt + 1;
  end
  // low runs only occur inside frames, so their length is a whole bit count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) lo_cnt <= 0;
    else lo_cnt <= txd ? 0 : lo_cnt + 1;
  end
  // parity over data and parity bits, sampled mid-bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) px <= 1'b0;
    else if (fcnt == BIT_CYCLES / 2) px <= 1'b0;
    else if (fcnt % BIT_CYCLES == BIT_CYCLES / 2 && fcnt < 10 * BIT_CYCLES)
      px <= px ^ txd;
  end
  ////////////////////////////////////////////////////////////////////////
  a_wait_first: assert property ((avs_read || avs_write) &&
    !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("first bus cycle not stalled");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus stall longer than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("stall without request");
  a_reset_idle: assert property ($rose(reset_n) |-> txd && !dtr)
    else $error("line not idle after reset");
  a_start_low: assert property (
    fcnt != 0 && fcnt < BIT_CYCLES |-> !txd)
    else $error("start bit not held low");
  a_stop_high: assert property (fcnt >= 10 * BIT_CYCLES |-> txd)
    else $error("stop bit not high");
  a_bit_whole: assert property (txd && lo_cnt != 0 |->
    lo_cnt % BIT_CYCLES == 0) else $error("bit time broken");
  a_parity_even: assert property (
    fcnt == 10 * BIT_CYCLES + BIT_CYCLES / 2 |-> !px)
    else $error("odd parity sent");
  a_dtr_rise: assert property ($rose(dtr) |->
    $past(avs_read || avs_write, 1) || $past(avs_read || avs_write, 2))
    else $error("dtr rose unasked");
endmodule // hmi_link_checker

bind hmi_serial_link_ctrl hmi_link_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .txd(txd), .dtr(dtr));

// [hmi_serial_link_ctrl_tb_top.sv]
// testbench top for the serial link controller
`include "hmi_link_consts.svh"
module hmi_serial_link_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 16;
  localparam int FRAME = 11 * BC;
  logic mclk, reset_n, ce, avs_read, avs_write, avs_waitrequest;
  logic rxd, txd, dsr, dtr;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  hmi_serial_link_ctrl #(.BIT_CYCLES(BC)) dut (.mclk(mclk),
    .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxd(rxd), .txd(txd), .dsr(dsr), .dtr(dtr));
  hmi_peer_model #(.BIT_CYCLES(BC)) peer (.mclk(mclk), .txd(txd), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bus master: hold until waitrequest is seen low at an edge
  task bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task wait_rx(input int n);
    int k;
    k = 0;
    while (peer.rx_q.size() < n && k < 4 * FRAME) begin
      @(posedge mclk);
      k++;
    end
  endtask
  task wait_txd_low;
    int k;
    k = 0;
    while (txd !== 1'b0 && k < 4 * FRAME) begin
      @(posedge mclk);
      k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    chk(32'(txd), 32'h1);
    chk(32'(dtr), 32'h0);
    bus_rd(`REG_CTRL, rd); chk(rd, 32'h0);
    // ready-in synced high and the empty receive sum reads as zero
    bus_rd(`REG_STATUS, rd); chk(rd, 32'h60);
    bus_rd(`REG_STATION, rd); chk(rd, 32'(peer.STATION));
    bus_wr(`REG_STATION, 32'hFFFF_FF07);
    bus_rd(`REG_STATION, rd); chk(rd, 32'h7);
    bus_wr(`REG_STATION, 32'h0);
    bus_wr(5'h18, 32'hFF);
    bus_rd(5'h18, rd); chk(rd, 32'h0);
    bus_rd(`REG_CHECK, rd); chk(rd, 32'h0);
    $display("test regs done");
  endtask
  // controller mode ignores the ready line; two characters back to back
  task t_ctrl_tx;
    dsr <= 1'b0;
    bus_wr(`REG_CTRL, 32'h2);
    bus_wr(`REG_TXDATA, 32'hA5);
    wait_txd_low();
    bus_wr(`REG_TXDATA, 32'h3C);
    wait_rx(2);
    chk(32'(peer.rx_q.size()), 32'h2);
    chk(32'(peer.rx_q.pop_front()), 32'hA5);
    chk(32'(peer.rx_q.pop_front()), 32'h3C);
    chk(32'(peer.err_cnt), 32'h0);
    bus_rd(`REG_CHECK, rd); chk({24'h0, rd[7:0]}, 32'h1F);
    dsr <= 1'b1;
    $display("test ctrl tx done");
  endtask
  task t_ctrl_rx;
    logic [7:0] msg [3];
    msg = '{8'h12, 8'h34, 8'hBA};
    bus_wr(`REG_CTRL, 32'h2);
    for (int i = 0; i < 3; i++) begin
      peer.send_char(msg[i], 1'b0);
      bus_rd(`REG_RXDATA, rd); chk(rd, 32'(msg[i]));
    end
    bus_rd(`REG_STATUS, rd); chk(rd & 32'h24, 32'h20);
    bus_rd(`REG_CHECK, rd); chk({24'h0, rd[15:8]}, 32'h0);
    peer.send_char(8'h55, 1'b1);
    bus_rd(`REG_RXDATA, rd);
    bus_rd(`REG_STATUS, rd); chk(rd & 32'h4, 32'h4);
    bus_wr(`REG_STATUS, 32'h1C);
    bus_rd(`REG_STATUS, rd); chk(rd & 32'h4, 32'h0);
    // a second byte while the first is unread is lost and flagged
    peer.send_char(8'h0F, 1'b0);
    peer.send_char(8'hF0, 1'b0);
    bus_rd(`REG_STATUS, rd); chk(rd & 32'h12, 32'h12);
    bus_rd(`REG_RXDATA, rd); chk(rd, 32'h0F);
    bus_wr(`REG_STATUS, 32'h10);
    bus_rd(`REG_STATUS, rd); chk(rd & 32'h12, 32'h0);
    $display("test ctrl rx done");
  endtask
  // host mode: ready line low holds sending, mid-character drop finishes it
  task t_host_dsr;
    bus_wr(`REG_CTRL, 32'h1);
    dsr <= 1'b0;
    peer.rx_q.delete();
    bus_wr(`REG_TXDATA, 32'h5A);
    repeat (3 * FRAME) @(posedge mclk);
    chk(32'(peer.rx_q.size()), 32'h0);
    dsr <= 1'b1;
    wait_rx(1);
    chk(32'(peer.rx_q.pop_front()), 32'h5A);
    bus_wr(`REG_TXDATA, 32'h81);
    wait_txd_low();
    bus_wr(`REG_TXDATA, 32'h42);
    dsr <= 1'b0;
    wait_rx(1);
    chk(32'(peer.rx_q.pop_front()), 32'h81);
    repeat (2 * FRAME) @(posedge mclk);
    chk(32'(peer.rx_q.size()), 32'h0);
    dsr <= 1'b1;
    wait_rx(1);
    chk(32'(peer.rx_q.pop_front()), 32'h42);
    $display("test host dsr done");
  endtask
  task t_host_dtr;
    repeat (3) @(posedge mclk);
    chk(32'(dtr), 32'h1);
    peer.send_char(8'h66, 1'b0);
    repeat (4) @(posedge mclk);
    chk(32'(dtr), 32'h0);
    bus_rd(`REG_RXDATA, rd); chk(rd, 32'h66);
    repeat (3) @(posedge mclk);
    chk(32'(dtr), 32'h1);
    // enable low freezes the receiver, so a byte sent then is never taken
    ce <= 1'b0;
    peer.send_char(8'h77, 1'b0);
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(32'(dtr), 32'h1);
    bus_wr(`REG_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    chk(32'(dtr), 32'h0);
    $display("test host dtr done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence; the clock enable stays high except inside t_host_dtr
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    dsr = 1'b1;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_ctrl_tx();
    t_ctrl_rx();
    t_host_dsr();
    t_host_dtr();
    give_verdict();
  end
endmodule // hmi_serial_link_ctrl_tb_top

// [tx_link_if.sv]
// carrier between the controller and its character transmitter
interface tx_link_if;
  logic start;
  logic [7:0] data;
  logic seven_bits;
  logic busy;
  modport ctrl (output start, output data, output seven_bits, input busy);
  modport engine (input start, input data, input seven_bits, output busy);
endinterface
